// ==== include/umsb_cfg.svh ====
// Purpose: Offsets, field positions, reset values and codes of the modem status,
//          special function and baud divisor registers.
// Assumes: Byte-wide registers at byte offsets within one channel block.
// Notes:   Definitions only; included by its bare name.
`ifndef UMSB_CFG_SVH
`define UMSB_CFG_SVH

// Register offsets
`define UMSB_OFF_DIV_LO 8'h00
`define UMSB_OFF_DIV_HI 8'h01
`define UMSB_OFF_OSC 8'h02
`define UMSB_OFF_MST 8'h06
`define UMSB_OFF_SFC 8'h07
`define UMSB_OFF_CNT15 8'h15
`define UMSB_OFF_CNT16 8'h16

// Line control bit that exposes the divisor bytes
`define UMSB_LCTL_DLAB_BIT 7

// Modem status fields
`define UMSB_MST_D_CTS 0
`define UMSB_MST_D_DSR 1
`define UMSB_MST_RI_EDGE 2
`define UMSB_MST_D_DCD 3
`define UMSB_MST_LVL_LSB 4

// Special function fields
`define UMSB_SFC_FORCE_TX 0
`define UMSB_SFC_AUTO_DSR_DTR 1
`define UMSB_SFC_ENHANCED 5
`define UMSB_SFC_SEL15 6
`define UMSB_SFC_SEL16 7
`define UMSB_SFC_WR_MASK 8'hF3

// Oversample field
`define UMSB_OSC_WR_MASK 8'h0F
`define UMSB_OSC_MAX_CODE 4'hC
`define UMSB_OSC_BASE 5'h10

// Reset values
`define UMSB_RST_BYTE 8'h00
`define UMSB_RST_DIV 16'h0000
`define UMSB_RST_NIBBLE 4'h0

`endif

// ==== include/umsb_pkg.sv ====
// Purpose: Types shared by the modem status and baud configuration logic.
// Assumes: Nothing beyond the cfg header.
// Notes:   Nothing is imported; users write umsb_pkg::name.
package umsb_pkg;

    typedef logic [7:0] umsb_byte_t;

    // Register selected by an address and the divisor-access bit
    typedef enum logic [2:0] {
        UMSB_SEL_NONE = 3'b000,
        UMSB_SEL_DIV_LO = 3'b001,
        UMSB_SEL_DIV_HI = 3'b010,
        UMSB_SEL_OSC = 3'b011,
        UMSB_SEL_MST = 3'b100,
        UMSB_SEL_SFC = 3'b101,
        UMSB_SEL_CNT15 = 3'b110,
        UMSB_SEL_CNT16 = 3'b111
    } umsb_sel_t;

endpackage

// ==== logic/umsb_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to clk_in.
// Notes:   The first stage feeds only the second; the level moves when stages two
//          and three agree, so a single metastable sample cannot make a glitch.
`timescale 1ns/1ps
module umsb_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Asynchronous pins
    input wire logic [WIDTH-1:0] async_in,
    // Filtered level
    output logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // Accept a new level only when the two settled stages agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level_out[i];
        end
    end

    // Register stages
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level_out <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level_out <= next_level;
        end
    end

endmodule // umsb_sync

// ==== logic/umsb_top.sv ====
// Purpose: Modem status tracking, special function controls and baud divisor /
//          oversample registers of one UART channel.
// Assumes: Single clock, synchronous reset; line control and modem control bits
//          arrive as same-clock inputs from neighbouring register logic.
// Notes:   Read data are registered one cycle after the read strobe.
// What this block does
// (RQ1) CTS change in either direction sets bit 0; a status read clears it.
// (RQ2) DSR toggle sets bit 1; a status read clears it.
// (RQ3) RI low-to-high sets bit 2 only; a status read clears it.
// (RQ4) DCD change sets bit 3; a status read clears it.
// (RQ5) Bits 7:4 show DCD, RI, DSR, CTS present levels, one means high.
// (RQ6) In loopback, output one drives ring status, output two carrier status.
// (RQ7) Control bit 0 forces transmission regardless of flow control; resets zero.
// (RQ8) Control bit 1 enables DSR/DTR automatic flow control; resets zero.
// (RQ9) Control bit 5 selects enhanced compatibility mode; resets zero.
// (RQ10) Control bit 6 makes offset 15h show line status count, else receive count.
// (RQ11) Control bit 7 makes offset 16h show transmit count, else sample clock.
// (RQ12) With line-control bit 7 set, offset 00h is divisor low byte, resets 00h.
// (RQ13) With line-control bit 7 set, offset 01h is divisor high byte, resets 00h.
// (RQ14) Offset 02h bits 3:0 pick oversampling 16 down to 4; other codes reserved.
// (RQ15) Divisor bytes form 16-bit divisor; one tick per count, oversample ticks per bit.
// (RQ16) Modem pins synchronised before edge detection; coincident read loses nothing.
// (RQ17) Sample clock register upper four bits read zero and ignore writes.
`timescale 1ns/1ps
`include "umsb_cfg.svh"
module umsb_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Register access
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // Neighbouring control registers
    input wire logic [7:0] line_control_register_in,
    input wire logic loopback_en_in,
    input wire logic general_output_one_in,
    input wire logic general_output_two_in,
    input wire logic dtr_request_in,
    input wire logic rx_room_in,
    // Modem pins from the serial peer
    input wire logic cts_pin_in,
    input wire logic dsr_pin_in,
    input wire logic ri_pin_in,
    input wire logic dcd_pin_in,
    // Counters shown through aliased offsets
    input wire logic [7:0] receive_fill_count_in,
    input wire logic [7:0] line_status_count_in,
    input wire logic [7:0] transmit_fill_count_in,
    // Control outputs
    output logic force_transmit_out,
    output logic auto_dsr_dtr_flow_out,
    output logic enhanced_mode_out,
    output logic tx_stall_out,
    output logic dtr_out,
    // Baud generation
    output logic [15:0] divisor_out,
    output logic [4:0] oversample_count_out,
    output logic sample_tick_out,
    output logic bit_tick_out
);

    // Decode an address against the divisor-access bit
    function automatic umsb_pkg::umsb_sel_t umsb_decode(input logic [7:0] addr,
                                                       input logic dlab);
        umsb_pkg::umsb_sel_t sel;
        sel = umsb_pkg::UMSB_SEL_NONE;
        if (dlab && addr == `UMSB_OFF_DIV_LO) begin
            sel = umsb_pkg::UMSB_SEL_DIV_LO;
        end else if (dlab && addr == `UMSB_OFF_DIV_HI) begin
            sel = umsb_pkg::UMSB_SEL_DIV_HI;
        end else if (dlab && addr == `UMSB_OFF_OSC) begin
            sel = umsb_pkg::UMSB_SEL_OSC;
        end else if (addr == `UMSB_OFF_MST) begin
            sel = umsb_pkg::UMSB_SEL_MST;
        end else if (addr == `UMSB_OFF_SFC) begin
            sel = umsb_pkg::UMSB_SEL_SFC;
        end else if (addr == `UMSB_OFF_CNT15) begin
            sel = umsb_pkg::UMSB_SEL_CNT15;
        end else if (addr == `UMSB_OFF_CNT16) begin
            sel = umsb_pkg::UMSB_SEL_CNT16;
        end
        return sel;
    endfunction

    // Oversample code to tick count; reserved codes fall back to sixteen
    function automatic logic [4:0] umsb_osc_value(input logic [3:0] code);
        logic [4:0] value;
        value = `UMSB_OSC_BASE;
        if (code <= `UMSB_OSC_MAX_CODE) begin
            value = `UMSB_OSC_BASE - {1'b0, code};
        end
        return value;
    endfunction

    logic dlab;
    umsb_pkg::umsb_sel_t wr_sel;
    umsb_pkg::umsb_sel_t rd_sel;
    logic [3:0] pin_level;
    logic [3:0] modem_level;
    logic [3:0] modem_prev;
    logic [3:0] next_modem_prev;
    logic [3:0] delta;
    logic [3:0] next_delta;
    logic [3:0] change_event;
    umsb_pkg::umsb_byte_t special_ctrl;
    umsb_pkg::umsb_byte_t next_special_ctrl;
    umsb_pkg::umsb_byte_t div_lo;
    umsb_pkg::umsb_byte_t next_div_lo;
    umsb_pkg::umsb_byte_t div_hi;
    umsb_pkg::umsb_byte_t next_div_hi;
    logic [3:0] osc_code;
    logic [3:0] next_osc_code;
    umsb_pkg::umsb_byte_t next_rdata;
    umsb_pkg::umsb_byte_t sts_view;
    logic [15:0] divisor;
    logic [4:0] osc_value;
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic [4:0] smp_cnt;
    logic [4:0] next_smp_cnt;
    logic next_sample_tick;
    logic next_bit_tick;
    logic next_tx_stall;
    logic next_dtr;

    assign dlab = line_control_register_in[`UMSB_LCTL_DLAB_BIT];
    assign wr_sel = umsb_decode(reg_addr_in, dlab);
    assign rd_sel = umsb_decode(reg_addr_in, dlab);

    // Pins pass three stages before any edge logic looks at them
    umsb_sync #(
        .WIDTH(4)
    ) u_modem_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({dcd_pin_in, ri_pin_in, dsr_pin_in, cts_pin_in}),
        .level_out(pin_level)
    ); // see (RQ16)

    // Loopback swaps ring and carrier for the general outputs; they are same-clock
    // signals so they need no synchroniser
    always_comb begin
        modem_level = pin_level;
        if (loopback_en_in) begin
            modem_level[2] = general_output_one_in; // see (RQ6)
            modem_level[3] = general_output_two_in; // see (RQ6)
        end
    end

    // Edge detection on the filtered levels
    always_comb begin
        change_event[0] = modem_level[0] ^ modem_prev[0]; // see (RQ1)
        change_event[1] = modem_level[1] ^ modem_prev[1]; // see (RQ2)
        change_event[2] = modem_level[2] & ~modem_prev[2]; // see (RQ3)
        change_event[3] = modem_level[3] ^ modem_prev[3]; // see (RQ4)
        next_modem_prev = modem_level;
    end

    // Change flags: a read clears them, but an event in the same cycle wins
    always_comb begin
        next_delta = delta;
        if (reg_rd_in && rd_sel == umsb_pkg::UMSB_SEL_MST) begin
            next_delta = 4'h0; // see (RQ1) (RQ2) (RQ3) (RQ4)
        end
        next_delta = next_delta | change_event; // see (RQ16)
    end

    // Delta and previous-level registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            modem_prev <= 4'h0;
            delta <= 4'h0;
        end else begin
            modem_prev <= next_modem_prev;
            delta <= next_delta;
        end
    end

    // Status view: present levels above the change flags
    assign sts_view = {modem_level, delta}; // see (RQ5)

    // Register writes; reserved bits 3:2 of the control register stay zero
    always_comb begin
        next_special_ctrl = special_ctrl;
        next_div_lo = div_lo;
        next_div_hi = div_hi;
        next_osc_code = osc_code;
        if (reg_wr_in) begin
            unique case (wr_sel)
                umsb_pkg::UMSB_SEL_SFC: begin
                    next_special_ctrl = reg_wdata_in & `UMSB_SFC_WR_MASK; // see (RQ7) (RQ8)
                end
                umsb_pkg::UMSB_SEL_DIV_LO: begin
                    next_div_lo = reg_wdata_in; // see (RQ12)
                end
                umsb_pkg::UMSB_SEL_DIV_HI: begin
                    next_div_hi = reg_wdata_in; // see (RQ13)
                end
                umsb_pkg::UMSB_SEL_OSC: begin
                    next_osc_code = reg_wdata_in[3:0]; // see (RQ14) (RQ17)
                end
                umsb_pkg::UMSB_SEL_CNT16: begin
                    // The alias reaches the sample clock only when it is shown there
                    if (!special_ctrl[`UMSB_SFC_SEL16]) begin
                        next_osc_code = reg_wdata_in[3:0]; // see (RQ11) (RQ17)
                    end
                end
                umsb_pkg::UMSB_SEL_MST,
                umsb_pkg::UMSB_SEL_CNT15,
                umsb_pkg::UMSB_SEL_NONE: begin
                    next_osc_code = osc_code;
                end
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            special_ctrl <= `UMSB_RST_BYTE; // see (RQ7) (RQ8) (RQ9) (RQ10) (RQ11)
            div_lo <= `UMSB_RST_BYTE; // see (RQ12)
            div_hi <= `UMSB_RST_BYTE; // see (RQ13)
            osc_code <= `UMSB_RST_NIBBLE;
        end else begin
            special_ctrl <= next_special_ctrl;
            div_lo <= next_div_lo;
            div_hi <= next_div_hi;
            osc_code <= next_osc_code;
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        next_rdata = `UMSB_RST_BYTE;
        if (reg_rd_in) begin
            unique case (rd_sel)
                umsb_pkg::UMSB_SEL_MST: begin
                    next_rdata = sts_view; // see (RQ5)
                end
                umsb_pkg::UMSB_SEL_SFC: begin
                    next_rdata = special_ctrl;
                end
                umsb_pkg::UMSB_SEL_DIV_LO: begin
                    next_rdata = div_lo; // see (RQ12)
                end
                umsb_pkg::UMSB_SEL_DIV_HI: begin
                    next_rdata = div_hi; // see (RQ13)
                end
                umsb_pkg::UMSB_SEL_OSC: begin
                    next_rdata = {4'h0, osc_code}; // see (RQ17)
                end
                umsb_pkg::UMSB_SEL_CNT15: begin
                    next_rdata = special_ctrl[`UMSB_SFC_SEL15] ? line_status_count_in
                                                              : receive_fill_count_in; // see (RQ10)
                end
                umsb_pkg::UMSB_SEL_CNT16: begin
                    next_rdata = special_ctrl[`UMSB_SFC_SEL16] ? transmit_fill_count_in
                                                              : {4'h0, osc_code}; // see (RQ11)
                end
                umsb_pkg::UMSB_SEL_NONE: begin
                    next_rdata = `UMSB_RST_BYTE;
                end
            endcase
        end
    end

    // Flow control: forced transmission overrides the DSR stall
    always_comb begin
        next_tx_stall = special_ctrl[`UMSB_SFC_AUTO_DSR_DTR] & ~modem_level[1]; // see (RQ8)
        if (special_ctrl[`UMSB_SFC_FORCE_TX]) begin
            next_tx_stall = 1'b0; // see (RQ7)
        end
        // DTR drops while auto control is on and the receiver has no room
        next_dtr = dtr_request_in;
        if (special_ctrl[`UMSB_SFC_AUTO_DSR_DTR]) begin
            next_dtr = dtr_request_in & rx_room_in; // see (RQ8)
        end
    end

    // Baud counters; a zero divisor holds the generator still rather than
    // ticking every cycle, which would be an unusable rate
    assign divisor = {div_hi, div_lo}; // see (RQ15)
    assign osc_value = umsb_osc_value(osc_code); // see (RQ14)

    always_comb begin
        next_div_cnt = div_cnt;
        next_smp_cnt = smp_cnt;
        next_sample_tick = 1'b0;
        next_bit_tick = 1'b0;
        if (divisor == `UMSB_RST_DIV) begin
            next_div_cnt = `UMSB_RST_DIV;
            next_smp_cnt = 5'h00;
        end else if (div_cnt >= divisor - 16'h0001) begin
            next_div_cnt = `UMSB_RST_DIV;
            next_sample_tick = 1'b1; // see (RQ15)
            if (smp_cnt >= osc_value - 5'h01) begin
                next_smp_cnt = 5'h00;
                next_bit_tick = 1'b1; // see (RQ15)
            end else begin
                next_smp_cnt = smp_cnt + 5'h01;
            end
        end else begin
            next_div_cnt = div_cnt + 16'h0001;
        end
    end

    // Output and counter registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= `UMSB_RST_BYTE;
            div_cnt <= `UMSB_RST_DIV;
            smp_cnt <= 5'h00;
            sample_tick_out <= 1'b0;
            bit_tick_out <= 1'b0;
            tx_stall_out <= 1'b0;
            dtr_out <= 1'b0;
        end else begin
            reg_rdata_out <= next_rdata;
            div_cnt <= next_div_cnt;
            smp_cnt <= next_smp_cnt;
            sample_tick_out <= next_sample_tick;
            bit_tick_out <= next_bit_tick;
            tx_stall_out <= next_tx_stall;
            dtr_out <= next_dtr;
        end
    end

    // Control bits straight from their flip-flops
    assign force_transmit_out = special_ctrl[`UMSB_SFC_FORCE_TX]; // see (RQ7)
    assign auto_dsr_dtr_flow_out = special_ctrl[`UMSB_SFC_AUTO_DSR_DTR]; // see (RQ8)
    assign enhanced_mode_out = special_ctrl[`UMSB_SFC_ENHANCED]; // see (RQ9)
    assign divisor_out = divisor;
    assign oversample_count_out = osc_value;

endmodule // umsb_top

// ==== verification/umsb_modem_peer.sv ====
// Purpose: Serial peer model that drives the four modem status pins.
// Assumes: The bench asks for levels; the pins follow off the clock.
// Notes: The lag keeps pin edges unrelated to clk_in, so the device must synchronise.
`timescale 1ns/1ps
module umsb_modem_peer (
    // Wanted levels: bit0 cts, bit1 dsr, bit2 ri, bit3 dcd
    input wire logic [3:0] want_in,
    // Pins toward the device
    output logic cts_out,
    output logic dsr_out,
    output logic ri_out,
    output logic dcd_out
);
    // Pins lag the request by 3 ns
    assign #3 {dcd_out, ri_out, dsr_out, cts_out} = want_in;
endmodule // umsb_modem_peer

// ==== verification/umsb_top_checker.sv ====
// Purpose: Port-level assertions for the modem status and baud config block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Sees only umsb_top ports; bound at the foot of this file.
`timescale 1ns/1ps
module umsb_top_checker (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Register access
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [7:0] line_control_register_in,
    // Controls and baud
    input wire logic force_transmit_out,
    input wire logic auto_dsr_dtr_flow_out,
    input wire logic enhanced_mode_out,
    input wire logic tx_stall_out,
    input wire logic [15:0] divisor_out,
    input wire logic [4:0] oversample_count_out,
    input wire logic sample_tick_out,
    input wire logic bit_tick_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Write strobes decoded against offset and divisor access
    logic ctl_wr;
    logic dlab_wr;
    assign ctl_wr = reg_wr_in && reg_addr_in == 8'h07;
    assign dlab_wr = reg_wr_in && line_control_register_in[7];

    force_bit_a: assert property (ctl_wr
        |=> force_transmit_out == $past(reg_wdata_in[0])) else $error("force bit wrong");
    auto_flow_a: assert property (ctl_wr
        |=> auto_dsr_dtr_flow_out == $past(reg_wdata_in[1])) else $error("auto flow bit wrong");
    enh_mode_a: assert property (ctl_wr
        |=> enhanced_mode_out == $past(reg_wdata_in[5])) else $error("enhanced bit wrong");
    div_low_a: assert property (dlab_wr && reg_addr_in == 8'h00
        |=> divisor_out[7:0] == $past(reg_wdata_in)) else $error("divisor low wrong");
    div_high_a: assert property (dlab_wr && reg_addr_in == 8'h01
        |=> divisor_out[15:8] == $past(reg_wdata_in)) else $error("divisor high wrong");
    osc_code_a: assert property (dlab_wr && reg_addr_in == 8'h02
        && reg_wdata_in[3:0] <= 4'hC
        |=> oversample_count_out == 5'h10 - $past(reg_wdata_in[3:0]))
        else $error("oversample decode wrong");
    osc_upper_a: assert property (reg_rd_in && reg_addr_in == 8'h02
        && line_control_register_in[7] |=> reg_rdata_out[7:4] == 4'h0)
        else $error("sample clock upper bits not zero");
    stall_force_a: assert property (force_transmit_out |=> !tx_stall_out)
        else $error("stall while forced");
    tick_pair_a: assert property (bit_tick_out |-> sample_tick_out)
        else $error("bit tick without sample tick");

    // Main scenarios reached
    cover property (bit_tick_out);
    cover property (tx_stall_out);
    cover property (reg_rd_in && reg_addr_in == 8'h06);
endmodule // umsb_top_checker

bind umsb_top umsb_top_checker u_checker (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .line_control_register_in(line_control_register_in),
    .force_transmit_out(force_transmit_out), .auto_dsr_dtr_flow_out(auto_dsr_dtr_flow_out),
    .enhanced_mode_out(enhanced_mode_out), .tx_stall_out(tx_stall_out),
    .divisor_out(divisor_out), .oversample_count_out(oversample_count_out),
    .sample_tick_out(sample_tick_out), .bit_tick_out(bit_tick_out)
);

// ==== verification/umsb_top_tb_top.sv ====
// Purpose: Self-checking bench for the modem status and baud config block.
// Assumes: 125 MHz clock, synchronous active-high reset.
// Notes: Register rows first, then baud, pins, loopback, flow and reset.
`timescale 1ns/1ps
module umsb_top_tb_top;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, line_control_register = 8'h00;
    logic wr = 1'b0, rd = 1'b0, lb = 1'b0, go1 = 1'b0, go2 = 1'b0, dtr_req = 1'b0, room = 1'b0;
    logic [3:0] want = 4'h0;
    logic cts, dsr, ri, dcd, stall, dtr_o, stick, btick;
    logic [7:0] rdata, v;
    logic [15:0] div, n;
    logic [4:0] osc;
    int num_errors = 0;
    int n_checks = 0;
    // Rows: write?, divisor access, offset, write data, expected read
    logic [25:0] rows [14] = '{
        {1'b1, 1'b1, 8'h00, 8'hA5, 8'hA5}, {1'b1, 1'b1, 8'h01, 8'h5A, 8'h5A},
        {1'b1, 1'b1, 8'h02, 8'hF7, 8'h07}, {1'b1, 1'b0, 8'h00, 8'h77, 8'h00},
        {1'b1, 1'b0, 8'h05, 8'h12, 8'h00}, {1'b1, 1'b0, 8'h07, 8'hFF, 8'hF3},
        {1'b0, 1'b0, 8'h16, 8'h00, 8'h5E}, {1'b0, 1'b0, 8'h15, 8'h00, 8'h3C},
        {1'b1, 1'b0, 8'h07, 8'h00, 8'h00}, {1'b0, 1'b0, 8'h15, 8'h00, 8'hC3},
        {1'b1, 1'b0, 8'h16, 8'h09, 8'h09}, {1'b0, 1'b1, 8'h02, 8'h00, 8'h09},
        {1'b1, 1'b0, 8'h06, 8'hFF, 8'h00}, {1'b0, 1'b1, 8'h00, 8'h00, 8'hA5}};
    // Pin steps: wanted levels and the status byte they should give
    logic [11:0] mods [6] = '{12'h111, 12'h554, 12'h110, 12'h332, 12'hBB8, 12'hAA1};

    umsb_modem_peer peer (.want_in(want), .cts_out(cts), .dsr_out(dsr), .ri_out(ri),
        .dcd_out(dcd));
    umsb_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .line_control_register_in(line_control_register), .loopback_en_in(lb), .general_output_one_in(go1),
        .general_output_two_in(go2), .dtr_request_in(dtr_req), .rx_room_in(room),
        .cts_pin_in(cts), .dsr_pin_in(dsr), .ri_pin_in(ri), .dcd_pin_in(dcd),
        .receive_fill_count_in(8'hC3), .line_status_count_in(8'h3C),
        .transmit_fill_count_in(8'h5E), .force_transmit_out(), .auto_dsr_dtr_flow_out(),
        .enhanced_mode_out(), .tx_stall_out(stall), .dtr_out(dtr_o), .divisor_out(div),
        .oversample_count_out(osc), .sample_tick_out(stick), .bit_tick_out(btick));

    // Free-running clock, 8 ns period
    initial begin
        forever #4 clk_in = ~clk_in;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One strobe cycle; read data is taken just after the answering edge
    task automatic access(input logic w, input logic d, input logic [7:0] a,
        input logic [7:0] wd);
        @(posedge clk_in);
        addr <= a;
        wdata <= wd;
        line_control_register <= {d, 7'h00};
        wr <= w;
        rd <= ~w;
        @(posedge clk_in);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // Cycles between two ticks of one kind, both waits bounded
    task automatic gap(input logic b);
        int k = 0;
        while ((b ? btick : stick) !== 1'b1 && k < 100) begin
            @(posedge clk_in);
            #1 k++;
        end
        n = 16'h0000;
        do begin
            @(posedge clk_in);
            #1 n++;
        end while ((b ? btick : stick) !== 1'b1 && n < 100);
    endtask

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i][25]) access(1'b1, rows[i][24], rows[i][23:16], rows[i][15:8]);
            access(1'b0, rows[i][24], rows[i][23:16], 8'h00);
            check("row read", v, rows[i][7:0]);
        end
        check("divisor", div, 16'h5AA5);
        // Every oversample code, one reserved code behaving as 16
        for (int c = 0; c < 14; c++) begin
            access(1'b1, 1'b1, 8'h02, 8'(c));
            check("oversample", osc, (c > 12) ? 16'h0010 : 16'(16 - c));
        end
        access(1'b1, 1'b1, 8'h00, 8'h03);
        access(1'b1, 1'b1, 8'h01, 8'h00);
        access(1'b1, 1'b1, 8'h02, 8'h0C);
        gap(1'b0);
        check("sample tick gap", n, 16'h0003);
        gap(1'b1);
        check("bit tick gap", n, 16'h000C);
        // Pin changes, each read twice: flags then cleared flags
        foreach (mods[i]) begin
            want <= mods[i][11:8];
            repeat (8) @(posedge clk_in);
            access(1'b0, 1'b0, 8'h06, 8'h00);
            check("modem status", v, mods[i][7:0]);
            access(1'b0, 1'b0, 8'h06, 8'h00);
            check("status after read", v, {mods[i][7:4], 4'h0});
        end
        // Loopback: outputs one and two stand in for ring and carrier
        @(posedge clk_in);
        lb <= 1'b1;
        go1 <= 1'b1;
        repeat (8) @(posedge clk_in);
        access(1'b0, 1'b0, 8'h06, 8'h00);
        access(1'b0, 1'b0, 8'h06, 8'h00);
        check("loopback status", v, 16'h0060);
        @(posedge clk_in);
        go2 <= 1'b1;
        repeat (4) @(posedge clk_in);
        access(1'b0, 1'b0, 8'h06, 8'h00);
        check("loopback carrier", v, 16'h00E8);
        @(posedge clk_in);
        lb <= 1'b0;
        // Auto flow: stall on low DSR, DTR follows receive room
        access(1'b1, 1'b0, 8'h07, 8'h02);
        @(posedge clk_in);
        dtr_req <= 1'b1;
        want <= 4'h8;
        repeat (8) @(posedge clk_in);
        room <= 1'b1;
        #1 check("stall", stall, 16'h0001);
        check("dtr no room", dtr_o, 16'h0000);
        repeat (2) @(posedge clk_in);
        #1 check("dtr room", dtr_o, 16'h0001);
        access(1'b1, 1'b0, 8'h07, 8'h03);
        repeat (2) @(posedge clk_in);
        #1 check("forced stall", stall, 16'h0000);
        // Second reset in mid-run restores reset values
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        #1 check("divisor reset", div, 16'h0000);
        check("oversample reset", osc, 16'h0010);
        foreach (rows[i]) begin
            if (i < 3) access(1'b0, 1'b1, rows[i][23:16], 8'h00);
            if (i == 3) access(1'b0, 1'b0, 8'h07, 8'h00);
            if (i < 4) check("reset value", v, 16'h0000);
        end
        stop_test();
    end
endmodule // umsb_top_tb_top
